// file: hw/wake_event_capture_signaling.v
// Wake pin, regular and diagnostic event capture with receive-pin signalling
//
// Function
// - Wake pin edges raise events per enables
// - Level status bit follows wake pin
// - Level valid in Normal or edge enabled
// - CAN wake, edge events disabled after reset
// - Power-on event set on leaving Off
// - Power-on, watchdog, frame error always captured
// - Overtemperature captured, never in Sleep
// - Serial failures captured outside Sleep
// - Watchdog overflow (Window or Timeout) or early trigger (Window only) captured
// - Watchdog reset: window now, timeout if pending
// - Supply undervoltage captured only while supply on
// - Bus silence only if armed while active
// - CAN failure on undervoltage or clamped transmit
// - Other events have individual capture enables
// - Enabled event sets its status bit
// - Receive pin low when offline, supply on
// - Event in Sleep wakes via Reset
// - Global register flags pending groups
// - Status bits clear by writing one
// - Sleep needs a regular wake enable
// - Clear releases pin, starts delay timer
// - Sleep command with pending goes Reset
`include "wake_evt_map.vh"

// ----------------------------------------
// One status group with capture enables
// ----------------------------------------
module evt_group #(
    parameter [7:0] IMPL = 8'h00, // Implemented status bits
    parameter [7:0] KEEP = 8'h00 // Always-captured bits
) (
    input wire sys_clk,
    input wire rst,
    input wire [7:0] raw_set, // Event pulses
    input wire st_wr, // Write to status register
    input wire en_wr, // Write to enable register
    input wire [7:0] wdata,
    output reg [7:0] st_reg,
    output reg [7:0] en_reg,
    output wire cleared // A set bit was cleared
);
    wire [7:0] clr; // Ones written over implemented bits
    wire [7:0] capt; // Events that are let through
    reg [7:0] st_next;
    assign clr = st_wr ? (wdata & IMPL) : `R_ZERO;
    assign capt = raw_set & (en_reg | KEEP) & IMPL;
    assign cleared = |(clr & st_reg);
    // Set wins over clear so a late event survives
    always @* begin
        st_next = (st_reg & ~clr) | capt;
    end

    // Status and enable storage
    always @(posedge sys_clk) begin
        if (rst) begin
            st_reg <= `R_ZERO;
            en_reg <= `R_ZERO;
        end else begin
            st_reg <= st_next;
            if (en_wr) begin
                en_reg <= wdata & IMPL & ~KEEP;
            end
        end
    end
endmodule // evt_group

// ----------------------------------------
// Top level
// ----------------------------------------
module wake_event_capture_signaling #(
    parameter DELAY_NS = `EVT_DELAY_NS // Event delay time in ns
) (
    input wire sys_clk,
    input wire rst,
    input wire wake_pin, // Raw wake pin level
    input wire [2:0] chip_mode_code, // Current chip mode
    input wire trx_offline, // Transceiver in CAN Offline
    input wire rstn_pin, // Reset pin level
    input wire left_off, // Pulse: left Off mode after power-up
    input wire otw_in, // Pulse: warning threshold exceeded
    input wire spi_count_err, // Pulse: clock count not 16/24/32
    input wire spi_code_err, // Pulse: illegal mode/watchdog code
    input wire spi_lock_err, // Pulse: write to locked register
    input wire wd_window, // Watchdog in Window mode
    input wire wd_timeout, // Watchdog in Timeout mode
    input wire wd_overflow, // Pulse: watchdog overflow
    input wire wd_early, // Pulse: trigger too early
    input wire vext_ov_in, // Pulse: sensor supply overvoltage
    input wire vext_uv_in, // Pulse: sensor supply undervoltage
    input wire mcu_uv_in, // Pulse: supply below 90 %
    input wire frame_err_in, // Pulse: frame detection error
    input wire bus_active, // Bus activity seen
    input wire silence_to, // Pulse: silence timeout elapsed
    input wire trx_off_uv, // Pulse: transceiver off, undervoltage
    input wire txd_clamp, // Pulse: transmit dominant clamp
    input wire can_wake_in, // Pulse: CAN wake-up detected
    input wire sleep_cmd, // Pulse: Sleep mode commanded
    input wire [6:0] reg_addr, // Register address
    input wire reg_wr, // Write strobe
    input wire reg_rd, // Read strobe
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg rxd_low, // Drive receive pin low
    output reg sleep_ok, // Pulse: Sleep entry allowed
    output reg sys_reset_req, // Pulse: go to Reset mode
    output reg wake_req // Pulse: supply on, Sleep to Reset
);
    // ----------------------------------------
    // Timing constants
    // ----------------------------------------
    localparam integer DLY_CYC_I = (DELAY_NS + `CLK_NS - 1) / `CLK_NS;
    localparam integer DLY_CYC = (DLY_CYC_I < 1) ? 1 : DLY_CYC_I;
    localparam [15:0] DLY_LOAD = DLY_CYC[15:0];
    localparam [15:0] CNT_ZERO = 16'h0000;
    localparam [15:0] CNT_ONE = 16'h0001;
    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    wire in_normal = (chip_mode_code == `MODE_NORMAL);
    wire in_sleep = (chip_mode_code == `MODE_SLEEP);
    wire mcu_on = in_normal | (chip_mode_code == `MODE_STANDBY);
    // ----------------------------------------
    // Wake pin synchroniser and edge detect
    // ----------------------------------------
    reg wake_s1_reg; // First stage, read only by second
    reg wake_s2_reg; // Synchronised level
    reg wake_prev_reg; // Previous synchronised sample
    // Two stages because the pin is slow and asynchronous
    always @(posedge sys_clk) begin
        if (rst) begin
            wake_s1_reg <= 1'b0;
            wake_s2_reg <= 1'b0;
            wake_prev_reg <= 1'b0;
        end else begin
            wake_s1_reg <= wake_pin;
            wake_s2_reg <= wake_s1_reg;
            wake_prev_reg <= wake_s2_reg;
        end
    end

    wire wake_rise = wake_s2_reg & ~wake_prev_reg;
    wire wake_fall = ~wake_s2_reg & wake_prev_reg;

    // ----------------------------------------
    // Bus silence arming
    // ----------------------------------------
    reg sil_arm_reg; // Enable seen while bus active
    wire [7:0] trx_en; // Transceiver enable register
    // Arm only when enabled with traffic, so idle power-up is quiet
    always @(posedge sys_clk) begin
        if (rst) begin
            sil_arm_reg <= 1'b0;
        end else if (!trx_en[`B_CBS]) begin
            sil_arm_reg <= 1'b0;
        end else if (bus_active) begin
            sil_arm_reg <= 1'b1;
        end else if (silence_to) begin
            sil_arm_reg <= 1'b0; // One event per silence
        end
    end

    // ----------------------------------------
    // Raw event vectors
    // ----------------------------------------
    reg [7:0] sys_raw;
    reg [7:0] sup_raw;
    reg [7:0] trx_raw;
    reg [7:0] wpe_raw;
    // Qualify sources by mode or state where needed before enables apply
    always @* begin
        sys_raw = `R_ZERO;
        sup_raw = `R_ZERO;
        trx_raw = `R_ZERO;
        wpe_raw = `R_ZERO;
        sys_raw[`B_PO] = left_off;
        sys_raw[`B_OTW] = otw_in & ~in_sleep;
        sys_raw[`B_SERIAL_FAILURE_EVENT] = (spi_count_err | spi_code_err | spi_lock_err)
            & ~in_sleep;
        sys_raw[`B_WDF] = (wd_overflow & (wd_window | wd_timeout))
            | (wd_early & wd_window);
        sup_raw[`B_SENSOR_SUPPLY_OVERVOLTAGE_EVENT] = vext_ov_in;
        sup_raw[`B_SENSOR_SUPPLY_UNDERVOLTAGE_EVENT] = vext_uv_in;
        sup_raw[`B_V1U] = mcu_uv_in & mcu_on;
        trx_raw[`B_FDE] = frame_err_in;
        trx_raw[`B_CBS] = silence_to & sil_arm_reg;
        trx_raw[`B_CF] = trx_off_uv | (txd_clamp & ~in_sleep);
        trx_raw[`B_CW] = can_wake_in & trx_offline;
        wpe_raw[`B_WPR] = wake_rise;
        wpe_raw[`B_WPF] = wake_fall;
    end

    // ----------------------------------------
    // Register write decode and status groups
    // ----------------------------------------
    wire [7:0] sys_st;
    wire [7:0] sup_st;
    wire [7:0] trx_st;
    wire [7:0] wpe_st;
    wire [7:0] sys_en;
    wire [7:0] sup_en;
    wire [7:0] wpe_en;
    wire [3:0] clr_hit; // Per-group actual clear
    evt_group #(.IMPL(`M_SYS), .KEEP(`K_SYS)) u_sys (
        .sys_clk(sys_clk), .rst(rst), .raw_set(sys_raw),
        .st_wr(reg_wr && reg_addr == `A_SYS_ST),
        .en_wr(reg_wr && reg_addr == `A_SYS_EN), .wdata(reg_wdata),
        .st_reg(sys_st), .en_reg(sys_en), .cleared(clr_hit[0]));
    evt_group #(.IMPL(`M_SUP), .KEEP(`K_SUP)) u_sup (
        .sys_clk(sys_clk), .rst(rst), .raw_set(sup_raw),
        .st_wr(reg_wr && reg_addr == `A_SUP_ST),
        .en_wr(reg_wr && reg_addr == `A_SUP_EN), .wdata(reg_wdata),
        .st_reg(sup_st), .en_reg(sup_en), .cleared(clr_hit[1]));
    evt_group #(.IMPL(`M_TRX), .KEEP(`K_TRX)) u_trx (
        .sys_clk(sys_clk), .rst(rst), .raw_set(trx_raw),
        .st_wr(reg_wr && reg_addr == `A_TRX_ST),
        .en_wr(reg_wr && reg_addr == `A_TRX_EN), .wdata(reg_wdata),
        .st_reg(trx_st), .en_reg(trx_en), .cleared(clr_hit[2]));
    evt_group #(.IMPL(`M_WPE), .KEEP(`K_WPE)) u_wpe (
        .sys_clk(sys_clk), .rst(rst), .raw_set(wpe_raw),
        .st_wr(reg_wr && reg_addr == `A_WPE_ST),
        .en_wr(reg_wr && reg_addr == `A_WPE_EN), .wdata(reg_wdata),
        .st_reg(wpe_st), .en_reg(wpe_en), .cleared(clr_hit[3]));

    // ----------------------------------------
    // Global status and level status
    // ----------------------------------------
    wire [7:0] glob_st;
    wire [7:0] lvl_st;
    wire any_pend = |glob_st;
    wire edge_en = wpe_en[`B_WPR] | wpe_en[`B_WPF];
    wire regular_en = edge_en | trx_en[`B_CW];
    assign glob_st = {4'h0, |wpe_st, |trx_st, |sup_st, |sys_st};
    // Level reads zero when it is not guaranteed valid
    assign lvl_st = {6'h00, wake_s2_reg & (in_normal | edge_en), 1'b0};

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    reg [7:0] rd_next;
    // Unmapped addresses read zero
    always @* begin
        case (reg_addr)
            `A_WAKE_LVL: rd_next = lvl_st;
            `A_GLOBAL: rd_next = glob_st;
            `A_SYS_ST: rd_next = sys_st;
            `A_SUP_ST: rd_next = sup_st;
            `A_TRX_ST: rd_next = trx_st;
            `A_WPE_ST: rd_next = wpe_st;
            `A_SYS_EN: rd_next = sys_en;
            `A_SUP_EN: rd_next = sup_en;
            `A_TRX_EN: rd_next = trx_en;
            `A_WPE_EN: rd_next = wpe_en;
            default: rd_next = `R_ZERO;
        endcase
    end

    // Data held until the next read
    always @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= `R_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= rd_next;
        end
    end

    // ----------------------------------------
    // Event delay timer and receive pin
    // ----------------------------------------
    reg [15:0] dly_cnt_reg; // Remaining delay cycles
    reg rstn_prev_reg; // Reset pin last cycle
    reg [15:0] dly_cnt_next;
    wire rstn_fall = rstn_prev_reg & ~rstn_pin;
    // Stop on reset pin fall, restart on any clear
    always @* begin
        if (rstn_fall) begin
            dly_cnt_next = CNT_ZERO;
        end else if (|clr_hit) begin
            dly_cnt_next = DLY_LOAD;
        end else if (dly_cnt_reg != CNT_ZERO) begin
            dly_cnt_next = dly_cnt_reg - CNT_ONE;
        end else begin
            dly_cnt_next = CNT_ZERO;
        end
    end

    // Pin held high while the timer runs to batch events
    always @(posedge sys_clk) begin
        if (rst) begin
            dly_cnt_reg <= CNT_ZERO;
            rstn_prev_reg <= 1'b1;
            rxd_low <= 1'b0;
        end else begin
            dly_cnt_reg <= dly_cnt_next;
            rstn_prev_reg <= rstn_pin;
            rxd_low <= trx_offline & mcu_on & any_pend
                & (dly_cnt_next == CNT_ZERO);
        end
    end

    // ----------------------------------------
    // Sleep entry, reset and wake requests
    // ----------------------------------------
    reg [7:0] sys_st_d; // Status last cycle, for new captures
    reg [7:0] sup_st_d;
    reg [7:0] trx_st_d;
    reg [7:0] wpe_st_d;
    wire any_capt = |{sys_st & ~sys_st_d, sup_st & ~sup_st_d,
        trx_st & ~trx_st_d, wpe_st & ~wpe_st_d};
    wire sleep_bad = ~regular_en | any_pend;
    wire wd_reset = (sys_raw[`B_WDF] & wd_window)
        | (wd_overflow & wd_timeout & sys_st[`B_WDF]);
    // One-cycle pulses, decided from current status
    always @(posedge sys_clk) begin
        if (rst) begin
            sys_st_d <= `R_ZERO;
            sup_st_d <= `R_ZERO;
            trx_st_d <= `R_ZERO;
            wpe_st_d <= `R_ZERO;
            sleep_ok <= 1'b0;
            sys_reset_req <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            sys_st_d <= sys_st;
            sup_st_d <= sup_st;
            trx_st_d <= trx_st;
            wpe_st_d <= wpe_st;
            sleep_ok <= sleep_cmd & ~sleep_bad;
            sys_reset_req <= (sleep_cmd & sleep_bad) | wd_reset;
            wake_req <= in_sleep & any_capt;
        end
    end
endmodule // wake_event_capture_signaling

// file: shared/wake_evt_map.vh
// Register map, field positions and mode codes of the wake/event capture block
`ifndef WAKE_EVT_MAP_VH
`define WAKE_EVT_MAP_VH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define A_WAKE_LVL 7'h4B
`define A_GLOBAL 7'h60
`define A_SYS_ST 7'h61
`define A_SUP_ST 7'h62
`define A_TRX_ST 7'h63
`define A_WPE_ST 7'h64
`define A_SYS_EN 7'h04
`define A_SUP_EN 7'h1C
`define A_TRX_EN 7'h23
`define A_WPE_EN 7'h4C
// ----------------------------------------
// Field positions
// ----------------------------------------
`define B_LVL 1
`define B_PO 4
`define B_OTW 2
`define B_SERIAL_FAILURE_EVENT 1
`define B_WDF 0
`define B_SENSOR_SUPPLY_OVERVOLTAGE_EVENT 2
`define B_SENSOR_SUPPLY_UNDERVOLTAGE_EVENT 1
`define B_V1U 0
`define B_FDE 5
`define B_CBS 4
`define B_CF 1
`define B_CW 0
`define B_WPR 1
`define B_WPF 0
`define B_G_WPE 3
`define B_G_TRX 2
`define B_G_SUP 1
`define B_G_SYS 0
// ----------------------------------------
// Masks: implemented bits and always-captured bits
// ----------------------------------------
`define M_SYS 8'h17
`define M_SUP 8'h07
`define M_TRX 8'h33
`define M_WPE 8'h03
`define K_SYS 8'h11
`define K_SUP 8'h00
`define K_TRX 8'h20
`define K_WPE 8'h00
`define R_ZERO 8'h00
// ----------------------------------------
// Chip mode codes
// ----------------------------------------
`define MODE_NORMAL 3'b111
`define MODE_STANDBY 3'b100
`define MODE_SLEEP 3'b001
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_NS 20
`define EVT_DELAY_NS 1000
`endif

// file: bench/wake_evt_asserts.sv
// Concurrent checks on the ports of the wake and event capture block
`include "wake_evt_map.vh"
module wake_evt_asserts #(
    parameter DELAY_NS = 1000 // Delay time; any value above 40 ns suits the hold below
) (
    input logic sys_clk,
    input logic rst,
    input logic wake_pin,
    input logic [2:0] chip_mode_code,
    input logic trx_offline,
    input logic wd_window,
    input logic wd_overflow,
    input logic wd_early,
    input logic sleep_cmd,
    input logic [6:0] reg_addr,
    input logic reg_rd,
    input logic [7:0] reg_rdata,
    input logic rxd_low,
    input logic sleep_ok,
    input logic sys_reset_req,
    input logic wake_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // Offline with the supply on: the only time the pin may be pulled
    wire sup_on = trx_offline
        && (chip_mode_code == `MODE_NORMAL || chip_mode_code == `MODE_STANDBY);
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    // Level read in Normal with the pin steady through the synchroniser
    sequence s_level_read;
        !$past(rst) && !$past(rst, 2) && !$past(rst, 3) && $past(wake_pin, 3) == wake_pin
            && $past(wake_pin, 2) == wake_pin && $past(wake_pin) == wake_pin
            && reg_rd && reg_addr == `A_WAKE_LVL && chip_mode_code == `MODE_NORMAL;
    endsequence
    // Pin released while signalling stays allowed: only a clear does that
    sequence s_clear_fall;
        $fell(rxd_low) && $past(sup_on) && sup_on;
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_rxd_cond;
        rxd_low |-> $past(sup_on);
    endproperty
    property p_clear_hold;
        s_clear_fall |-> !rxd_low [*3];
    endproperty
    property p_level;
        s_level_read |=> reg_rdata == {6'h00, $past(wake_pin), 1'b0};
    endproperty
    property p_sleep_answer;
        sleep_cmd |=> sleep_ok || sys_reset_req;
    endproperty
    property p_sleep_ok_cause;
        sleep_ok |-> $past(sleep_cmd) && !$past(rxd_low);
    endproperty
    property p_pend_sleep;
        sleep_cmd && rxd_low |=> sys_reset_req && !sleep_ok;
    endproperty
    property p_window;
        wd_window && (wd_overflow || wd_early) |=> sys_reset_req;
    endproperty
    property p_reset_cause;
        sys_reset_req |-> $past(sleep_cmd) || $past(wd_overflow) || $past(wd_early);
    endproperty
    property p_wake_sleep;
        wake_req |-> $past(chip_mode_code) == `MODE_SLEEP;
    endproperty
    a_rxd_cond: assert property (p_rxd_cond)
        else $error("receive pin low while not allowed");
    a_clear_hold: assert property (p_clear_hold)
        else $error("receive pin back low before delay");
    a_level: assert property (p_level)
        else $error("level status differs from pin");
    a_sleep_answer: assert property (p_sleep_answer)
        else $error("sleep command left unanswered");
    a_sleep_ok_cause: assert property (p_sleep_ok_cause)
        else $error("sleep accepted without command or with pending");
    a_pend_sleep: assert property (p_pend_sleep)
        else $error("sleep with pending event not reset");
    a_window: assert property (p_window)
        else $error("window failure gave no reset");
    a_reset_cause: assert property (p_reset_cause)
        else $error("reset request without cause");
    a_wake_sleep: assert property (p_wake_sleep)
        else $error("wake request outside sleep");
endmodule // wake_evt_asserts

bind wake_event_capture_signaling wake_evt_asserts #(.DELAY_NS(DELAY_NS)) i_wake_evt_asserts (
    .sys_clk(sys_clk), .rst(rst), .wake_pin(wake_pin), .chip_mode_code(chip_mode_code),
    .trx_offline(trx_offline), .wd_window(wd_window), .wd_overflow(wd_overflow),
    .wd_early(wd_early), .sleep_cmd(sleep_cmd), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rxd_low(rxd_low), .sleep_ok(sleep_ok),
    .sys_reset_req(sys_reset_req), .wake_req(wake_req));

// file: bench/host_model.sv
// Host model: register port master and receive pin pull-up
module host_model (
    input logic sys_clk,
    input logic rxd_low,
    input logic [7:0] reg_rdata,
    output logic [6:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    output logic rxd_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pulled up unless the device pulls it down
    assign rxd_line = rxd_low ? 1'b0 : 1'b1;
    initial begin
        reg_addr = 7'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // One write, taken at the next rising edge
    task wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    // One read; data stands until the next read
    task rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
    // Clear only what was seen set, so late events survive
    task service(input logic [6:0] a, output logic [7:0] d);
        rd(a, d);
        wr(a, d);
    endtask
endmodule // host_model

// file: bench/tb_wake_event_capture_signaling.sv
// Self-checking bench for the wake and event capture block
`include "wake_evt_map.vh"
module tb_wake_event_capture_signaling;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst = 1, wake_pin = 1, trx_offline = 1, bus_active = 0;
    logic wd_window = 0, wd_timeout = 0, reg_wr, reg_rd, rxd_low, rxd_line;
    logic sleep_ok, sys_reset_req, wake_req;
    logic [2:0] chip_mode_code = `MODE_STANDBY;
    logic [15:0] pls = 16'h0000; // One bit per event pulse input
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rdv;
    int errors = 0, checks = 0, cycles = 0, n_rst = 0, n_ok = 0, n_wake = 0;
    // Short delay time keeps the run brief: 5 cycles
    wake_event_capture_signaling #(.DELAY_NS(100)) i_wake_event_capture_signaling (
        .sys_clk(sys_clk), .rst(rst), .wake_pin(wake_pin), .chip_mode_code(chip_mode_code),
        .trx_offline(trx_offline), .wd_window(wd_window), .wd_timeout(wd_timeout),
        .bus_active(bus_active), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rxd_low(rxd_low), .sleep_ok(sleep_ok),
        .sys_reset_req(sys_reset_req), .wake_req(wake_req),
        .rstn_pin(1'b1), .left_off(pls[0]), .otw_in(pls[1]), .spi_count_err(pls[2]),
        .spi_code_err(pls[3]), .spi_lock_err(pls[4]), .wd_overflow(pls[5]), .wd_early(pls[6]),
        .vext_ov_in(pls[7]), .vext_uv_in(pls[8]), .mcu_uv_in(pls[9]), .frame_err_in(pls[10]),
        .silence_to(pls[11]), .trx_off_uv(pls[12]), .txd_clamp(pls[13]),
        .can_wake_in(pls[14]), .sleep_cmd(pls[15]));
    host_model i_host_model (.sys_clk(sys_clk), .rxd_low(rxd_low), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .rxd_line(rxd_line));
    always #10 sys_clk = ~sys_clk;
    // Count output pulses; cut a hang short
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        n_rst <= n_rst + sys_reset_req;
        n_ok <= n_ok + sleep_ok;
        n_wake <= n_wake + wake_req;
        if (cycles == 5000) begin
            errors = errors + 1;
            end_of_test();
        end
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task pulse(input int i);
        @(negedge sys_clk);
        pls[i] = 1'b1;
        @(negedge sys_clk);
        pls[i] = 1'b0;
    endtask
    task rchk(input logic [6:0] a, input logic [7:0] e);
        i_host_model.rd(a, rdv);
        chk(rdv, e);
    endtask
    task end_of_test();
        if (errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Reset state, unmapped place, level hidden in Standby
    task t_reset();
        logic [6:0] a [11];
        a = '{7'h4B, 7'h60, 7'h61, 7'h62, 7'h63, 7'h64, 7'h04, 7'h1C, 7'h23, 7'h4C, 7'h7F};
        foreach (a[k]) rchk(a[k], 8'h00);
        chk({7'h00, rxd_line}, 8'h01);
    endtask
    // Always-captured events, timeout reset, clear and delay timer
    task t_always();
        int r0;
        r0 = n_rst;
        wd_timeout = 1'b1;
        pulse(0);
        pulse(10);
        pulse(5);
        pulse(5);
        repeat (2) @(negedge sys_clk);
        chk(8'(n_rst - r0), 8'h01);
        rchk(7'h61, 8'h11);
        rchk(7'h60, 8'h05);
        chk({7'h00, rxd_line}, 8'h00);
        i_host_model.wr(7'h63, 8'h00);
        rchk(7'h63, 8'h20);
        i_host_model.service(7'h61, rdv);
        @(negedge sys_clk);
        chk({7'h00, rxd_line}, 8'h01);
        repeat (6) @(negedge sys_clk);
        chk({7'h00, rxd_line}, 8'h00);
        i_host_model.wr(7'h63, 8'h20);
        repeat (8) @(negedge sys_clk);
        chk({7'h00, rxd_line}, 8'h01);
        wd_timeout = 1'b0;
    endtask
    // Enable-gated events in Normal; watchdog events refused outside its modes
    task t_enabled();
        chip_mode_code = `MODE_NORMAL;
        pulse(1);
        rchk(7'h61, 8'h00);
        i_host_model.wr(7'h04, 8'h06);
        i_host_model.wr(7'h1C, 8'h07);
        i_host_model.wr(7'h23, 8'h13);
        rchk(7'h23, 8'h13);
        bus_active = 1'b1;
        @(negedge sys_clk);
        bus_active = 1'b0;
        for (int i = 1; i <= 14; i++) pulse(i);
        rchk(7'h61, 8'h06);
        rchk(7'h62, 8'h07);
        rchk(7'h63, 8'h33);
        for (int g = 7'h61; g <= 7'h63; g++) i_host_model.service(7'(g), rdv);
        rchk(7'h60, 8'h00);
    endtask
    // Wake pin edges and level in Normal
    task t_wake();
        i_host_model.wr(7'h4C, 8'h03);
        rchk(7'h4B, 8'h02);
        wake_pin = 1'b0;
        // Two synchroniser stages and the capture edge before status shows
        repeat (3) @(negedge sys_clk);
        rchk(7'h64, 8'h01);
        rchk(7'h4B, 8'h00);
        wake_pin = 1'b1;
        repeat (3) @(negedge sys_clk);
        rchk(7'h64, 8'h03);
        i_host_model.service(7'h64, rdv);
    endtask
    // Early trigger in Window mode
    task t_window();
        int r0;
        r0 = n_rst;
        wd_window = 1'b1;
        pulse(6);
        repeat (2) @(negedge sys_clk);
        chk(8'(n_rst - r0), 8'h01);
        rchk(7'h61, 8'h01);
        i_host_model.service(7'h61, rdv);
        wd_window = 1'b0;
    endtask
    // Sleep protection, refusals in Sleep, wake-up from Sleep
    task t_sleep();
        int r0;
        int k0;
        int w0;
        r0 = n_rst;
        k0 = n_ok;
        w0 = n_wake;
        i_host_model.wr(7'h4C, 8'h00);
        i_host_model.wr(7'h23, 8'h00);
        pulse(15);
        i_host_model.wr(7'h4C, 8'h01);
        pulse(15);
        wake_pin = 1'b0;
        repeat (6) @(negedge sys_clk);
        pulse(15);
        repeat (2) @(negedge sys_clk);
        chk(8'(n_rst - r0), 8'h02);
        chk(8'(n_ok - k0), 8'h01);
        chip_mode_code = `MODE_SLEEP;
        i_host_model.service(7'h64, rdv);
        pulse(1);
        pulse(2);
        rchk(7'h61, 8'h00);
        wake_pin = 1'b1;
        repeat (6) @(negedge sys_clk);
        wake_pin = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk(8'(n_wake - w0), 8'h01);
        rchk(7'h64, 8'h01);
    endtask
    initial begin
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        t_reset();
        t_always();
        t_enabled();
        t_wake();
        t_window();
        t_sleep();
        end_of_test();
    end
endmodule // tb_wake_event_capture_signaling
